/* design/dcg_regs.vh */
`ifndef DCG_REGS_VH
`define DCG_REGS_VH

// Register indices behind the sequencer data port
`define DCG_IDX_RAMDAC_CLOCK_CONTROL     8'h18
`define DCG_IDX_PIN_SELECT_DAC_SUPPLY    8'h1a
`define DCG_IDX_SUPPLY_SENSE_CLK_SOURCE  8'h1b
`define DCG_IDX_TV_PERIPHERAL_GATING     8'h1c
`define DCG_IDX_STREAM_CLOCK_GATING      8'h1d
`define DCG_IDX_CONTROLLER_GATING        8'h1e

// Reset values
`define DCG_RST_RAMDAC_CLOCK_CONTROL     8'h00
`define DCG_RST_PIN_SELECT_DAC_SUPPLY    8'h00
`define DCG_RST_SUPPLY_SENSE_CLK_SOURCE  8'h00
`define DCG_RST_TV_PERIPHERAL_GATING     8'h00
`define DCG_RST_STREAM_CLOCK_GATING      8'h00
`define DCG_RST_CONTROLLER_GATING        8'h00

// Writable bit masks; reserved bits read zero unless noted
`define DCG_WMASK_PIN_SELECT             8'hb0
`define DCG_WMASK_SUPPLY_SENSE           8'hfe
`define DCG_WMASK_TV_PERIPHERAL          8'hfc
`define DCG_WMASK_STREAM                 8'hf8
`define DCG_WMASK_CONTROLLER             8'h9d

// ramdac_clock_control fields
`define DCG_B_TEST_COUNTER_ENABLE        0
`define DCG_B_TEST_COUNTER_RESET         1
`define DCG_B_TEST_RED_DRIVE             2
`define DCG_B_TEST_GREEN_DRIVE           3
`define DCG_B_TEST_BLUE_DRIVE            4
`define DCG_B_RAMDAC_POWER_DOWN          5
`define DCG_B_LOOKUP_WRITE_CYCLE         6
`define DCG_B_CLOCK_DOUBLED_ENABLE       7

// pin_select_dac_supply fields
`define DCG_B_STROBE_PIN_SELECT          4
`define DCG_B_POLARITY_PIN_SELECT        5
`define DCG_B_DAC_SUPPLY_SELECT          7

// supply_sense_clock_source fields
`define DCG_B_DAC_SUPPLY_SENSED          0
`define DCG_B_FORCE_DOT_CLOCK_SOURCE     7

// tv_peripheral_clock_gating fields
`define DCG_B_TV_DISABLE_GATE            2
`define DCG_B_TV_STANDBY_GATE            3
`define DCG_B_TV_SUSPEND_GATE            4
`define DCG_B_PERIPH_BUS_DISABLE_GATE    5
`define DCG_B_PERIPH_BUS_STANDBY_GATE    6
`define DCG_B_PERIPH_BUS_SUSPEND_GATE    7

// stream_clock_gating fields
`define DCG_B_STREAM_BRANCH1_DISABLE     3
`define DCG_B_STREAM_BRANCH1_STANDBY     4
`define DCG_B_STREAM_BRANCH1_SUSPEND     5
`define DCG_B_STREAM_BRANCH2_STANDBY     6
`define DCG_B_STREAM_BRANCH2_SUSPEND     7

// controller_clock_gating fields
`define DCG_B_FIRST_CTRL_DISABLE_GATE    0
`define DCG_B_SECOND_CTRL_DISABLE_GATE   2
`define DCG_B_SECOND_CTRL_STANDBY_DOWN   3
`define DCG_B_SECOND_CTRL_SUSPEND_DOWN   4
`define DCG_B_BUS_IF_SUSPEND_GATE        7

// display_routing_control bits used for controller enables and DAC-off
`define DCG_B_ROUTE_SELECT               1
`define DCG_B_ROUTE_SHARE                2
`define DCG_B_ROUTE_DUAL                 4
`define DCG_B_ROUTE_DAC_KEEP             5

// Lookup write lengths in dot-clock cycles
`define DCG_LUT_WRITE_SLOW               2'h2
`define DCG_LUT_WRITE_FAST               2'h1

// Dot-clock parameter source code for the enhanced pair
`define DCG_SRC_ENHANCED                 2'h3

// Gated clock slots
`define DCG_GATE_TV                      0
`define DCG_GATE_PERIPH                  1
`define DCG_GATE_STREAM1                 2
`define DCG_GATE_STREAM2                 3
`define DCG_GATE_CTRL1                   4
`define DCG_GATE_CTRL2                   5
`define DCG_GATE_BUS_IF                  6
`define DCG_GATE_COUNT                   7

`endif

/* design/dcg_clock_gate.v */
`timescale 1ns/1ps
module dcg_clock_gate (
    // Clock to be gated and its reset
    input  wire clk_in,
    input  wire rst,
    // Run request from the register domain
    input  wire run_req,
    // Gated clock
    output wire clk_out
);

    reg sync1_ff;
    reg sync2_ff;
    reg run_ff;

    // Bring the request into the gated clock's own domain
    always @(posedge clk_in or posedge rst) begin
        if (rst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= run_req;
            sync2_ff <= sync1_ff;
        end
    end

    // Change only while the clock is low, so no pulse is cut short
    always @(negedge clk_in or posedge rst) begin
        if (rst) begin
            run_ff <= 1'b1;
        end else begin
            run_ff <= sync2_ff;
        end
    end

    assign clk_out = clk_in & run_ff;

endmodule

/* design/dcg_top.v */
`timescale 1ns/1ps
`include "dcg_regs.vh"
module dcg_top #(
    parameter TEST_COUNT_WIDTH = 16
) (
    // Clock and reset
    input  wire                        mclk,
    input  wire                        rst,
    // Indexed sequencer port (port_sel 0 = index, 1 = data)
    input  wire                        port_sel,
    input  wire                        port_wr,
    input  wire                        port_rd,
    input  wire [7:0]                  port_wdata,
    output wire [7:0]                  port_rdata,
    // Power state and unit status from the rest of the chip
    input  wire                        standby_mode,
    input  wire                        suspend_mode,
    input  wire                        tv_encoder_enabled,
    input  wire                        periph_bus_enabled,
    input  wire [1:0]                  stream_mode,
    input  wire [7:0]                  display_routing_control,
    input  wire                        dac_off_request,
    // Dot-clock parameter selection
    input  wire [1:0]                  clock_select,
    output wire [1:0]                  dot_clock_param_source,
    // RAMDAC test and control
    input  wire [7:0]                  pixel_red,
    input  wire [7:0]                  pixel_green,
    input  wire [7:0]                  pixel_blue,
    output wire [7:0]                  test_data_bus,
    output wire                        test_data_valid,
    output wire [TEST_COUNT_WIDTH-1:0] test_count,
    output wire                        ramdac_power_down,
    output wire                        lookup_retain,
    output wire [1:0]                  lookup_write_cycles,
    output wire                        clock_doubled_enable,
    // Supply sensing and selection
    input  wire                        dac_supply_sensed_pin,
    output wire                        dac_supply_5v,
    // Shared pins and their candidate functions
    input  wire                        general_output_zero,
    input  wire                        stream_write_strobe,
    input  wire                        rom_enable_out,
    input  wire                        panel_polarity,
    output wire                        shared_pin_a,
    output wire                        shared_pin_b,
    // Controller two power control
    output wire                        second_ctrl_power_down,
    // Clocks to be gated
    input  wire                        tv_clock,
    input  wire                        periph_bus_clock,
    input  wire                        dot_clock,
    input  wire                        bus_if_clock,
    // Gated clocks
    output wire                        tv_clock_gated,
    output wire                        periph_bus_clock_gated,
    output wire                        stream_branch1_clock,
    output wire                        stream_branch2_clock,
    output wire                        first_ctrl_clock,
    output wire                        second_ctrl_clock,
    output wire                        bus_if_clock_gated
);

    // Register state
    reg [7:0]                  index_ff;
    reg [7:0]                  ramdac_clock_control_ff;
    reg [7:0]                  pin_select_dac_supply_ff;
    reg [7:0]                  supply_sense_clock_source_ff;
    reg [7:0]                  tv_peripheral_clock_gating_ff;
    reg [7:0]                  stream_clock_gating_ff;
    reg [7:0]                  controller_clock_gating_ff;
    reg [7:0]                  rdata_ff;
    reg [TEST_COUNT_WIDTH-1:0] test_count_ff;
    reg [7:0]                  test_data_ff;
    reg                        test_valid_ff;
    reg                        sense_sync1_ff;
    reg                        sense_sync2_ff;
    reg                        sensed_ff;
    reg                        shared_pin_a_ff;
    reg                        shared_pin_b_ff;
    reg                        ramdac_pd_ff;
    reg                        ctrl2_pd_ff;
    reg [1:0]                  param_source_ff;
    reg [`DCG_GATE_COUNT-1:0]  run_ff;

    reg [7:0]                  nxt_rdata;
    reg [7:0]                  nxt_test_data;
    reg [`DCG_GATE_COUNT-1:0]  nxt_run;

    wire data_wr = port_wr & port_sel;
    wire data_rd = port_rd & port_sel;
    wire wr_ramdac = data_wr & (index_ff == `DCG_IDX_RAMDAC_CLOCK_CONTROL);
    wire wr_pinsel = data_wr & (index_ff == `DCG_IDX_PIN_SELECT_DAC_SUPPLY);
    wire wr_sense  = data_wr & (index_ff == `DCG_IDX_SUPPLY_SENSE_CLK_SOURCE);
    wire wr_tvp    = data_wr & (index_ff == `DCG_IDX_TV_PERIPHERAL_GATING);
    wire wr_stream = data_wr & (index_ff == `DCG_IDX_STREAM_CLOCK_GATING);
    wire wr_ctrl   = data_wr & (index_ff == `DCG_IDX_CONTROLLER_GATING);

    // Only a write carrying a one clears the counter; a zero is ignored
    wire test_clear = wr_ramdac & port_wdata[`DCG_B_TEST_COUNTER_RESET];

    wire [7:0] rcc = ramdac_clock_control_ff;
    wire [7:0] tpg = tv_peripheral_clock_gating_ff;
    wire [7:0] scg = stream_clock_gating_ff;
    wire [7:0] ccg = controller_clock_gating_ff;
    wire [7:0] rte = display_routing_control;

    // Controller enable decode from the routing control
    wire ctrl1_enabled = ~rte[`DCG_B_ROUTE_SELECT] |
                         (~rte[`DCG_B_ROUTE_SHARE] & rte[`DCG_B_ROUTE_DUAL]);
    wire ctrl2_enabled = rte[`DCG_B_ROUTE_SELECT] |
                         (rte[`DCG_B_ROUTE_SHARE] & rte[`DCG_B_ROUTE_DUAL]);

    // Index register and the writable registers
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            index_ff                      <= 8'h00;
            ramdac_clock_control_ff       <= `DCG_RST_RAMDAC_CLOCK_CONTROL;
            pin_select_dac_supply_ff      <= `DCG_RST_PIN_SELECT_DAC_SUPPLY;
            supply_sense_clock_source_ff  <= `DCG_RST_SUPPLY_SENSE_CLK_SOURCE;
            tv_peripheral_clock_gating_ff <= `DCG_RST_TV_PERIPHERAL_GATING;
            stream_clock_gating_ff        <= `DCG_RST_STREAM_CLOCK_GATING;
            controller_clock_gating_ff    <= `DCG_RST_CONTROLLER_GATING;
        end else begin
            if (port_wr & ~port_sel) begin
                index_ff <= port_wdata;
            end
            if (wr_ramdac) begin
                ramdac_clock_control_ff <= port_wdata;
            end
            if (wr_pinsel) begin
                pin_select_dac_supply_ff <= port_wdata & `DCG_WMASK_PIN_SELECT;
            end
            if (wr_sense) begin
                supply_sense_clock_source_ff <= port_wdata & `DCG_WMASK_SUPPLY_SENSE;
            end
            if (wr_tvp) begin
                tv_peripheral_clock_gating_ff <= port_wdata & `DCG_WMASK_TV_PERIPHERAL;
            end
            if (wr_stream) begin
                stream_clock_gating_ff <= port_wdata & `DCG_WMASK_STREAM;
            end
            if (wr_ctrl) begin
                controller_clock_gating_ff <= port_wdata & `DCG_WMASK_CONTROLLER;
            end
        end
    end

    // Read mux; unknown indices answer zero
    always @* begin
        nxt_rdata = rdata_ff;
        if (data_rd) begin
            case (index_ff)
                `DCG_IDX_RAMDAC_CLOCK_CONTROL:    nxt_rdata = rcc;
                `DCG_IDX_PIN_SELECT_DAC_SUPPLY:   nxt_rdata = pin_select_dac_supply_ff;
                `DCG_IDX_SUPPLY_SENSE_CLK_SOURCE: nxt_rdata = {
                    supply_sense_clock_source_ff[7:1], sensed_ff};
                `DCG_IDX_TV_PERIPHERAL_GATING:    nxt_rdata = tpg;
                `DCG_IDX_STREAM_CLOCK_GATING:     nxt_rdata = scg;
                `DCG_IDX_CONTROLLER_GATING:       nxt_rdata = ccg;
                default:                          nxt_rdata = 8'h00;
            endcase
        end else if (port_rd) begin
            nxt_rdata = index_ff;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign port_rdata = rdata_ff;

    // Test counter: clear wins over counting in the same cycle
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            test_count_ff <= {TEST_COUNT_WIDTH{1'b0}};
        end else if (test_clear) begin
            test_count_ff <= {TEST_COUNT_WIDTH{1'b0}};
        end else if (rcc[`DCG_B_TEST_COUNTER_ENABLE]) begin
            test_count_ff <= test_count_ff + {{(TEST_COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign test_count = test_count_ff;

    // Colour test drive; several selected components merge by OR
    always @* begin
        nxt_test_data = 8'h00;
        if (rcc[`DCG_B_TEST_RED_DRIVE]) begin
            nxt_test_data = nxt_test_data | pixel_red;
        end
        if (rcc[`DCG_B_TEST_GREEN_DRIVE]) begin
            nxt_test_data = nxt_test_data | pixel_green;
        end
        if (rcc[`DCG_B_TEST_BLUE_DRIVE]) begin
            nxt_test_data = nxt_test_data | pixel_blue;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            test_data_ff  <= 8'h00;
            test_valid_ff <= 1'b0;
        end else begin
            test_data_ff  <= nxt_test_data;
            test_valid_ff <= |rcc[`DCG_B_TEST_BLUE_DRIVE:`DCG_B_TEST_RED_DRIVE];
        end
    end

    assign test_data_bus   = test_data_ff;
    assign test_data_valid = test_valid_ff;

    // Sensed supply is a pin: two flops before it is latched
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sense_sync1_ff <= 1'b0;
            sense_sync2_ff <= 1'b0;
            sensed_ff      <= 1'b0;
        end else begin
            sense_sync1_ff <= dac_supply_sensed_pin;
            sense_sync2_ff <= sense_sync1_ff;
            sensed_ff      <= sense_sync2_ff;
        end
    end

    // Software choice of supply always wins over the sensed value
    assign dac_supply_5v = pin_select_dac_supply_ff[`DCG_B_DAC_SUPPLY_SELECT];

    // Power, pin routing and parameter source, all registered
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ramdac_pd_ff    <= 1'b0;
            ctrl2_pd_ff     <= 1'b0;
            shared_pin_a_ff <= 1'b0;
            shared_pin_b_ff <= 1'b0;
            param_source_ff <= 2'h0;
        end else begin
            ramdac_pd_ff <= rcc[`DCG_B_RAMDAC_POWER_DOWN] |
                            (dac_off_request & ~rte[`DCG_B_ROUTE_DAC_KEEP]);
            ctrl2_pd_ff  <= (ccg[`DCG_B_SECOND_CTRL_STANDBY_DOWN] & standby_mode) |
                            (ccg[`DCG_B_SECOND_CTRL_SUSPEND_DOWN] & suspend_mode);
            shared_pin_a_ff <= pin_select_dac_supply_ff[`DCG_B_STROBE_PIN_SELECT] ?
                               stream_write_strobe : general_output_zero;
            shared_pin_b_ff <= pin_select_dac_supply_ff[`DCG_B_POLARITY_PIN_SELECT] ?
                               panel_polarity : rom_enable_out;
            param_source_ff <= supply_sense_clock_source_ff[`DCG_B_FORCE_DOT_CLOCK_SOURCE] ?
                               `DCG_SRC_ENHANCED : clock_select;
        end
    end

    assign ramdac_power_down      = ramdac_pd_ff;
    assign second_ctrl_power_down = ctrl2_pd_ff;
    assign shared_pin_a           = shared_pin_a_ff;
    assign shared_pin_b           = shared_pin_b_ff;
    assign dot_clock_param_source = param_source_ff;

    // Power-down never clears lookup contents; held high constantly
    assign lookup_retain        = 1'b1;
    assign lookup_write_cycles  = rcc[`DCG_B_LOOKUP_WRITE_CYCLE] ?
                                  `DCG_LUT_WRITE_FAST : `DCG_LUT_WRITE_SLOW;
    assign clock_doubled_enable = rcc[`DCG_B_CLOCK_DOUBLED_ENABLE];

    // Run requests for each gated branch; 1 lets the clock through
    always @* begin
        nxt_run = {`DCG_GATE_COUNT{1'b1}};
        nxt_run[`DCG_GATE_TV] = ~((tpg[`DCG_B_TV_DISABLE_GATE] & ~tv_encoder_enabled) |
                                  (tpg[`DCG_B_TV_STANDBY_GATE] & standby_mode) |
                                  (tpg[`DCG_B_TV_SUSPEND_GATE] & suspend_mode));
        nxt_run[`DCG_GATE_PERIPH] =
            ~((tpg[`DCG_B_PERIPH_BUS_DISABLE_GATE] & ~periph_bus_enabled) |
              (tpg[`DCG_B_PERIPH_BUS_STANDBY_GATE] & standby_mode) |
              (tpg[`DCG_B_PERIPH_BUS_SUSPEND_GATE] & suspend_mode));
        nxt_run[`DCG_GATE_STREAM1] =
            ~((scg[`DCG_B_STREAM_BRANCH1_DISABLE] & (stream_mode == 2'h0)) |
              (scg[`DCG_B_STREAM_BRANCH1_STANDBY] & standby_mode) |
              (scg[`DCG_B_STREAM_BRANCH1_SUSPEND] & suspend_mode));
        // Branch 2 ignores the stream mode: its logic must stay alive
        nxt_run[`DCG_GATE_STREAM2] =
            ~((scg[`DCG_B_STREAM_BRANCH2_STANDBY] & standby_mode) |
              (scg[`DCG_B_STREAM_BRANCH2_SUSPEND] & suspend_mode));
        nxt_run[`DCG_GATE_CTRL1] =
            ~(ccg[`DCG_B_FIRST_CTRL_DISABLE_GATE] & ~ctrl1_enabled);
        nxt_run[`DCG_GATE_CTRL2] =
            ~(ccg[`DCG_B_SECOND_CTRL_DISABLE_GATE] & ~ctrl2_enabled);
        nxt_run[`DCG_GATE_BUS_IF] =
            ~(ccg[`DCG_B_BUS_IF_SUSPEND_GATE] & suspend_mode);
    end

    // Registered so the gate synchronisers see a clean level
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_ff <= {`DCG_GATE_COUNT{1'b1}};
        end else begin
            run_ff <= nxt_run;
        end
    end

    // Source clocks per slot; stream branches both come from the dot clock
    wire [`DCG_GATE_COUNT-1:0] src_clk = {bus_if_clock, dot_clock, dot_clock,
                                          dot_clock, dot_clock, periph_bus_clock,
                                          tv_clock};
    wire [`DCG_GATE_COUNT-1:0] gated_clk;

    genvar g;
    generate
        for (g = 0; g < `DCG_GATE_COUNT; g = g + 1) begin : gen_gate
            dcg_clock_gate u_gate (
                .clk_in  (src_clk[g]),
                .rst     (rst),
                .run_req (run_ff[g]),
                .clk_out (gated_clk[g])
            );
        end
    endgenerate

    assign tv_clock_gated         = gated_clk[`DCG_GATE_TV];
    assign periph_bus_clock_gated = gated_clk[`DCG_GATE_PERIPH];
    assign stream_branch1_clock   = gated_clk[`DCG_GATE_STREAM1];
    assign stream_branch2_clock   = gated_clk[`DCG_GATE_STREAM2];
    assign first_ctrl_clock       = gated_clk[`DCG_GATE_CTRL1];
    assign second_ctrl_clock      = gated_clk[`DCG_GATE_CTRL2];
    assign bus_if_clock_gated     = gated_clk[`DCG_GATE_BUS_IF];

endmodule

/* verification/dcg_top_properties.sv */
`timescale 1ns/1ps
module dcg_props #(parameter TEST_COUNT_WIDTH = 16) (
    // Register port, pixel sources and power states
    input logic                        mclk, rst, port_sel, port_wr, port_rd,
    input logic [7:0]                  port_wdata, port_rdata, pixel_red, pixel_green, pixel_blue,
    input logic                        standby_mode, suspend_mode, dot_clock,
    input logic                        general_output_zero, stream_write_strobe,
    input logic [1:0]                  clock_select,
    // Observed outputs
    input logic [7:0]                  test_data_bus,
    input logic [TEST_COUNT_WIDTH-1:0] test_count,
    input logic [1:0]                  dot_clock_param_source, lookup_write_cycles,
    input logic                        lookup_retain, shared_pin_a, stream_branch2_clock
);
    logic [7:0] idx_ff, last_ff;
    // Shadow of the index and of the last byte written at 0x18
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            idx_ff <= 8'h00;
            last_ff <= 8'h00;
        end else if (port_wr && !port_sel) begin
            idx_ff <= port_wdata;
        end else if (port_wr && idx_ff == 8'h18) begin
            last_ff <= port_wdata;
        end
    end
    a_lut_retain: assert property (@(posedge mclk) disable iff (rst) lookup_retain)
        else $error("lookup memory not retained");
    a_count_step: assert property (@(posedge mclk) disable iff (rst)
        !$past(rst) && test_count != $past(test_count)
        |-> test_count == $past(test_count) + 1'b1 || test_count == '0)
        else $error("test counter jumped");
    a_bus_source: assert property (@(posedge mclk) disable iff (rst) !$past(rst)
        |-> (test_data_bus & ~($past(pixel_red) | $past(pixel_green) | $past(pixel_blue))) == 8'h00)
        else $error("test bus bit without source");
    a_lut_length: assert property (@(posedge mclk) disable iff (rst)
        lookup_write_cycles == (last_ff[6] ? 2'h1 : 2'h2))
        else $error("bad lookup write length");
    a_param_source: assert property (@(posedge mclk) disable iff (rst)
        !$past(rst) && dot_clock_param_source != 2'h3 |-> dot_clock_param_source == $past(clock_select))
        else $error("parameter source not clock select");
    a_pin_a_source: assert property (@(posedge mclk) disable iff (rst) !$past(rst)
        |-> shared_pin_a == $past(general_output_zero) || shared_pin_a == $past(stream_write_strobe))
        else $error("shared pin from no source");
    a_ctrl_readback: assert property (@(posedge mclk) disable iff (rst)
        port_rd && port_sel && idx_ff == 8'h18 |=> port_rdata == last_ff)
        else $error("control register readback wrong");
    a_branch2_run: assert property (@(negedge dot_clock) disable iff (rst)
        (!standby_mode && !suspend_mode) [*8] |-> stream_branch2_clock)
        else $error("branch two stopped while active");
endmodule
bind dcg_top dcg_props #(.TEST_COUNT_WIDTH(TEST_COUNT_WIDTH)) u_props (.*);

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    logic mclk = 0, rst = 1, sclk = 0, port_sel = 0, port_wr = 0, port_rd = 0;
    logic [7:0] port_wdata = 8'h00, display_routing_control = 8'h14;
    logic [7:0] pixel_red = 8'h01, pixel_green = 8'h02, pixel_blue = 8'h84;
    logic standby_mode = 0, suspend_mode = 0, tv_encoder_enabled = 1, periph_bus_enabled = 1;
    logic dac_off_request = 0, dac_supply_sensed_pin = 0, general_output_zero = 1;
    logic stream_write_strobe = 0, rom_enable_out = 1, panel_polarity = 0;
    logic [1:0] stream_mode = 2'h1, clock_select = 2'h1;
    // All gated sources share one clock unrelated to mclk
    wire tv_clock = sclk, periph_bus_clock = sclk, dot_clock = sclk, bus_if_clock = sclk;
    wire [7:0] port_rdata, test_data_bus;
    wire [15:0] test_count;
    wire [1:0] dot_clock_param_source, lookup_write_cycles;
    wire test_data_valid, ramdac_power_down, lookup_retain, clock_doubled_enable;
    wire dac_supply_5v, shared_pin_a, shared_pin_b, second_ctrl_power_down;
    wire tv_clock_gated, periph_bus_clock_gated, stream_branch1_clock, stream_branch2_clock;
    wire first_ctrl_clock, second_ctrl_clock, bus_if_clock_gated;
    integer fail_count = 0, compares = 0, i;
    logic [15:0] a;
    dcg_top #(.TEST_COUNT_WIDTH(16)) uut (.*);
    always #2.5 mclk = ~mclk;
    always #6 sclk = ~sclk;
    task chk(input [15:0] g, e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task wr(input [7:0] x, d);
        @(posedge mclk); port_sel <= 0; port_wr <= 1; port_wdata <= x;
        @(posedge mclk); port_sel <= 1; port_wdata <= d;
        @(posedge mclk); port_wr <= 0;
    endtask
    task rd(input [7:0] x, e);
        @(posedge mclk); port_sel <= 0; port_wr <= 1; port_wdata <= x;
        @(posedge mclk); port_wr <= 0; port_sel <= 1; port_rd <= 1;
        @(posedge mclk); port_rd <= 0;
        @(negedge mclk); chk(port_rdata, e);
    endtask
    // Reset values, then an unmapped index that must ignore writes
    task t_reset;
        for (i = 0; i < 6; i++) rd(i == 0 ? 8'h18 : 8'h19 + i, 8'h00);
        wr(8'h19, 8'h55); rd(8'h19, 8'h00);
        @(posedge mclk); port_sel <= 0; port_rd <= 1;
        @(posedge mclk); port_rd <= 0;
        @(negedge mclk); chk(port_rdata, 8'h19);
    endtask
    task t_counter;
        wr(8'h18, 8'h01); cyc(2); a = test_count; cyc(5); chk(test_count, a + 16'd5);
        wr(8'h18, 8'h00); cyc(2); a = test_count; cyc(3); chk(test_count, a);
        wr(8'h18, 8'h02); cyc(2); chk(test_count, 16'h0000); rd(8'h18, 8'h02);
    endtask
    task t_colour;
        for (i = 0; i < 3; i++) begin
            wr(8'h18, 8'h04 << i); cyc(2);
            chk(test_data_bus, i == 0 ? pixel_red : i == 1 ? pixel_green : pixel_blue);
        end
        wr(8'h18, 8'h1c); cyc(2); chk(test_data_bus, 8'h87); chk(test_data_valid, 1);
    endtask
    task t_power;
        wr(8'h18, 8'h20); cyc(2); chk(ramdac_power_down, 1); chk(lookup_retain, 1);
        chk(test_data_valid, 0);
        wr(8'h18, 8'h00); @(posedge mclk); dac_off_request <= 1;
        cyc(2); chk(ramdac_power_down, 1);
        @(posedge mclk); display_routing_control <= 8'h34;
        cyc(2); chk(ramdac_power_down, 0);
        wr(8'h18, 8'h40); cyc(2); chk(lookup_write_cycles, 1); chk(clock_doubled_enable, 0);
        wr(8'h18, 8'h80); cyc(2); chk(lookup_write_cycles, 2);
        chk(clock_doubled_enable, 1);
    endtask
    task t_pins_supply;
        wr(8'h1a, 8'h00); cyc(2); chk({shared_pin_a, shared_pin_b, dac_supply_5v}, 3'b110);
        wr(8'h1a, 8'hb0); cyc(2); chk({shared_pin_a, shared_pin_b, dac_supply_5v}, 3'b001);
        @(posedge mclk); stream_write_strobe <= 1; panel_polarity <= 1; dac_supply_sensed_pin <= 1;
        cyc(5); chk({shared_pin_a, shared_pin_b}, 2'b11); rd(8'h1b, 8'h01);
        wr(8'h1b, 8'hff); rd(8'h1b, 8'hff); chk(dot_clock_param_source, 3);
        @(posedge mclk); dac_supply_sensed_pin <= 0; clock_select <= 2'h2;
        wr(8'h1b, 8'h00); cyc(5); rd(8'h1b, 8'h00); chk(dot_clock_param_source, 2);
    endtask
    task gc(input s, u, en, input [1:0] sm, input [7:0] rt, input [6:0] ex, mk, input p);
        @(posedge mclk); standby_mode <= s; suspend_mode <= u; stream_mode <= sm;
        tv_encoder_enabled <= en; periph_bus_enabled <= en; display_routing_control <= rt;
        cyc(12); @(posedge sclk); #3;
        chk({bus_if_clock_gated, second_ctrl_clock, first_ctrl_clock, stream_branch2_clock,
             stream_branch1_clock, periph_bus_clock_gated, tv_clock_gated} & mk, ex);
        chk(second_ctrl_power_down, p);
    endtask
    // Every gate enabled, then each class of stop condition in turn
    task t_gates;
        for (i = 0; i < 3; i++) wr(8'h1c + i, 8'hff);
        rd(8'h1c, 8'hfc); rd(8'h1d, 8'hf8); rd(8'h1e, 8'h9d);
        gc(0, 0, 1, 2'h1, 8'h14, 7'h7f, 7'h7f, 0);
        gc(0, 0, 0, 2'h0, 8'h02, 7'h68, 7'h7f, 0);
        gc(0, 0, 1, 2'h1, 8'h00, 7'h5f, 7'h7f, 0);
        gc(1, 0, 1, 2'h1, 8'h14, 7'h50, 7'h5f, 1);
        gc(0, 1, 1, 2'h1, 8'h14, 7'h10, 7'h5f, 1);
        for (i = 0; i < 3; i++) wr(8'h1c + i, 8'h00);
        gc(1, 1, 0, 2'h0, 8'h02, 7'h7f, 7'h7f, 0);
    endtask
    task tally_and_finish;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Run takes under two microseconds; cut off well beyond that
    initial begin
        #200000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 0;
        t_reset;
        t_counter;
        t_colour;
        t_power;
        t_pins_supply;
        t_gates;
        tally_and_finish;
    end
endmodule
